// [core/pic_defs.vh]
`ifndef PIC_DEFS_VH
`define PIC_DEFS_VH
// I/O port of the primary mask register.
`define PIC_MASK_PORT      8'h21
// I/O port of the secondary mask register.
`define PIC_MASK2_PORT     8'ha1
// Command ports of both controllers.
`define PIC_CMD_PORT       8'h20
`define PIC_CMD2_PORT      8'ha0
// Service-done command code.
`define PIC_DONE_CMD       8'h20
// Reset value of each mask register: all lines blocked.
`define PIC_MASK_RST       8'hff
// Vector base of each controller.
`define PIC_VEC_BASE1      8'h08
`define PIC_VEC_BASE2      8'h70
// Primary input that carries the secondary controller.
`define PIC_CASCADE_LINE   3'h2
`endif

// [core/pic_top.v]
`timescale 1ns/100ps
// Overview of operation
// - Two cascaded controllers give 15 usable inputs.
// - Eight inputs each, rising edge registers request.
// - Interrupt only unmasked winning requests.
// - Mask one blocks, mask zero allows.
// - Primary mask readable and writable at 21h.
// - Input zero highest, input seven lowest.
// - Higher priority nests, others wait; secondary lines wait while the cascade line is in service.
// - Acknowledge returns 8-bit vector of winner.
// - Default uses: timer, keyboard, serial, disk.
`include "pic_defs.vh"

module pic_top (
    // Clock, reset and enable.
    input  wire        i_core_clk,
    input  wire        i_resetn,
    input  wire        i_ce,
    // Peripheral request lines, primary then secondary.
    input  wire [7:0]  i_request_input_n,
    input  wire [7:0]  i_request2_input_n,
    // Processor I/O port access.
    input  wire [7:0]  i_io_addr,
    input  wire [7:0]  i_io_wdata,
    input  wire        i_io_wr,
    input  wire        i_io_rd,
    output reg  [7:0]  o_io_rdata,
    // Interrupt to processor and acknowledge.
    input  wire        i_int_ack,
    output reg         o_int,
    output reg  [7:0]  o_vector
);

    // Index of the highest-ranked set bit, with a found flag in bit 3.
    // The loop walks downwards, so the lowest index is written last and
    // wins: line 0 always ranks first and line 7 always ranks last.
    function [3:0] prio_pick;
        input [7:0] v;
        integer k;
        begin
            prio_pick = 4'h0;
            for (k = 7; k >= 0; k = k - 1) begin
                if (v[k]) begin
                    prio_pick = {1'b1, k[2:0]};
                end
            end
        end
    endfunction

    // Lines that rank strictly above every line now in service.
    // A line of equal or lower rank stays out until a service done.
    function [7:0] above_mask;
        input [7:0] busy;
        integer k;
        reg hit;
        begin
            above_mask = 8'h00;
            hit = 1'b0;
            for (k = 0; k < 8; k = k + 1) begin
                if (busy[k]) begin
                    hit = 1'b1;
                end
                if (!hit) begin
                    above_mask[k] = 1'b1;
                end
            end
        end
    endfunction

    // One-hot select of a line number.
    function [7:0] line_bit;
        input [2:0] n;
        begin
            line_bit = 8'h01 << n;
        end
    endfunction

    // Pin synchronisers: three stages for all sixteen request lines.
    // A new level is believed only once the second and third stages
    // agree, so a pin that moves near a clock edge cannot give a half
    // seen edge. Only the second stage reads the first.
    reg  [15:0] sync1_ff;
    reg  [15:0] sync2_ff;
    reg  [15:0] sync3_ff;
    reg  [15:0] level_ff;
    wire [15:0] agree;
    wire [15:0] nxt_level;
    wire [15:0] rise;

    // Settled level and its low-to-high edge; the level resets low, which
    // is the idle level of the pins, so no false edge follows reset.
    assign agree     = ~(sync2_ff ^ sync3_ff);
    assign nxt_level = (agree & sync3_ff) | (~agree & level_ff);
    assign rise      = nxt_level & ~level_ff;

    // Controller state: masks, pending requests and lines in service.
    reg  [7:0]  interrupt_mask_ff;
    reg  [7:0]  mask2_ff;
    reg  [7:0]  irr1_ff;
    reg  [7:0]  irr2_ff;
    reg  [7:0]  srv1_ff;
    reg  [7:0]  srv2_ff;

    // Decision wires of both controllers.
    wire [7:0]  cand2;
    wire [3:0]  pick2;
    wire [7:0]  casc;
    wire [7:0]  irr1_eff;
    wire [7:0]  cand1;
    wire [3:0]  pick1;
    wire        via2;
    wire [7:0]  bit1;
    wire [7:0]  bit2;
    wire        ack;

    // Secondary decision: unmasked pending lines above its in-service set.
    assign cand2    = irr2_ff & ~mask2_ff & above_mask(srv2_ff);
    assign pick2    = prio_pick(cand2);
    // Eight secondary lines share one primary line, so fifteen lines reach
    // the processor; the system's own uses leave 10 free for peripherals.
    assign casc     = line_bit(`PIC_CASCADE_LINE);
    // The secondary's output stands as a request on the cascade line.
    assign irr1_eff = irr1_ff | (pick2[3] ? casc : 8'h00);
    // Primary decision: a line interrupts only when unmasked and winning.
    assign cand1    = irr1_eff & ~interrupt_mask_ff & above_mask(srv1_ff);
    assign pick1    = prio_pick(cand1);
    assign via2     = pick1[3] && (pick1[2:0] == `PIC_CASCADE_LINE);
    assign bit1     = line_bit(pick1[2:0]);
    assign bit2     = line_bit(pick2[2:0]);
    // An acknowledge with no winner present is ignored.
    assign ack      = i_int_ack && pick1[3];

    // Service-done decoding: a write of the done code to a command port
    // releases the highest-ranked line in service on that controller.
    wire        done1;
    wire        done2;
    wire [3:0]  top1;
    wire [3:0]  top2;
    wire [7:0]  clr1;
    wire [7:0]  clr2;

    assign done1 = i_io_wr && (i_io_addr == `PIC_CMD_PORT)
                   && (i_io_wdata == `PIC_DONE_CMD);
    assign done2 = i_io_wr && (i_io_addr == `PIC_CMD2_PORT)
                   && (i_io_wdata == `PIC_DONE_CMD);
    assign top1  = prio_pick(srv1_ff);
    assign top2  = prio_pick(srv2_ff);
    assign clr1  = (done1 && top1[3]) ? line_bit(top1[2:0]) : 8'h00;
    assign clr2  = (done2 && top2[3]) ? line_bit(top2[2:0]) : 8'h00;

    // Next pending, in-service and vector values. A new edge wins over an
    // acknowledge that clears the same line, and a new acknowledge wins
    // over a service done that falls in the same cycle.
    wire [7:0]  take1;
    wire [7:0]  take2;
    wire [7:0]  nxt_irr1;
    wire [7:0]  nxt_irr2;
    wire [7:0]  nxt_srv1;
    wire [7:0]  nxt_srv2;
    wire [7:0]  nxt_vector;

    assign take1      = (ack && !via2) ? bit1 : 8'h00;
    assign take2      = (ack && via2) ? bit2 : 8'h00;
    // The cascade pin itself is ignored; that line belongs to the secondary.
    assign nxt_irr1   = (irr1_ff & ~take1) | (rise[7:0] & ~casc);
    assign nxt_irr2   = (irr2_ff & ~take2) | rise[15:8];
    assign nxt_srv1   = (srv1_ff & ~clr1) | (ack ? bit1 : 8'h00);
    assign nxt_srv2   = (srv2_ff & ~clr2) | take2;
    // Line 0 carries the timer, 1 the keyboard, 3 and 4 the serial ports
    // and 6 the disks; each gets the vector of its own line number.
    assign nxt_vector = via2 ? (`PIC_VEC_BASE2 + {5'h00, pick2[2:0]})
                             : (`PIC_VEC_BASE1 + {5'h00, pick1[2:0]});

    // Synchronisers and pending requests.
    always @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            sync1_ff <= 16'h0000;
            sync2_ff <= 16'h0000;
            sync3_ff <= 16'h0000;
            level_ff <= 16'h0000;
            irr1_ff  <= 8'h00;
            irr2_ff  <= 8'h00;
        end else if (i_ce) begin
            sync1_ff <= {i_request2_input_n, i_request_input_n};
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
            level_ff <= nxt_level;
            irr1_ff  <= nxt_irr1;
            irr2_ff  <= nxt_irr2;
        end
    end

    // Mask registers; each is written whole by the processor.
    always @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            interrupt_mask_ff <= `PIC_MASK_RST;
            mask2_ff          <= `PIC_MASK_RST;
        end else if (i_ce) begin
            if (i_io_wr && (i_io_addr == `PIC_MASK_PORT)) begin
                interrupt_mask_ff <= i_io_wdata;
            end
            if (i_io_wr && (i_io_addr == `PIC_MASK2_PORT)) begin
                mask2_ff <= i_io_wdata;
            end
        end
    end

    // Lines in service, interrupt line and vector.
    always @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            srv1_ff  <= 8'h00;
            srv2_ff  <= 8'h00;
            o_int    <= 1'b0;
            o_vector <= 8'h00;
        end else if (i_ce) begin
            srv1_ff <= nxt_srv1;
            srv2_ff <= nxt_srv2;
            // The line drops at the edge that takes the acknowledge.
            o_int   <= pick1[3] && !ack;
            if (ack) begin
                o_vector <= nxt_vector;
            end
        end
    end

    // Read data: masks and lines in service; unmapped ports read zero.
    // The data stands until the next read.
    always @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_io_rdata <= 8'h00;
        end else if (i_ce && i_io_rd) begin
            case (i_io_addr)
                `PIC_MASK_PORT:  o_io_rdata <= interrupt_mask_ff;
                `PIC_MASK2_PORT: o_io_rdata <= mask2_ff;
                `PIC_CMD_PORT:   o_io_rdata <= srv1_ff;
                `PIC_CMD2_PORT:  o_io_rdata <= srv2_ff;
                default:         o_io_rdata <= 8'h00;
            endcase
        end
    end

endmodule

// [dv/pic_host.sv]
`timescale 1ns/100ps
module pic_host (
    // Clock and interrupt in.
    input  wire i_core_clk,
    input  wire i_int,
    // Acknowledge out.
    output reg  o_int_ack
);
    // Pulses acknowledge once for each raised interrupt.
    initial o_int_ack = 1'b0;
    always @(negedge i_core_clk) o_int_ack <= i_int & ~o_int_ack;
endmodule

// [dv/pic_top_props.sv]
`timescale 1ns/100ps
module pic_top_props (
    // Clock and reset.
    input wire       i_core_clk,
    input wire       i_resetn,
    // Watched ports.
    input wire       i_ce,
    input wire [7:0] i_io_addr,
    input wire [7:0] i_io_wdata,
    input wire       i_io_wr,
    input wire       i_io_rd,
    input wire [7:0] o_io_rdata,
    input wire       i_int_ack,
    input wire       o_int,
    input wire [7:0] o_vector
);
    reg [7:0] mask_ff;
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_resetn);
    // Shadow of the primary mask as the processor writes it.
    always @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) mask_ff <= 8'hff;
        else if (i_ce && i_io_wr && i_io_addr == 8'h21) mask_ff <= i_io_wdata;
    end
    sequence s_ack;
        i_ce && i_int_ack && o_int;
    endsequence
    sequence s_rd;
        i_ce && i_io_rd && !i_io_wr;
    endsequence
    a_ack_drops: assert property (s_ack |-> ##[1:2] !o_int)
        else $error("Interrupt held after ack.");
    a_vec_range: assert property (s_ack |=> ##[0:1] (o_vector inside {[8'h08:8'h09],
        [8'h0b:8'h0f], [8'h70:8'h77]})) else $error("Bad vector.");
    a_vec_hold: assert property (!(i_ce && i_int_ack) [*2] |=> $stable(o_vector))
        else $error("Vector moved.");
    a_mask_read: assert property (s_rd ##0 (i_io_addr == 8'h21) |=> o_io_rdata == $past(mask_ff))
        else $error("Mask read wrong.");
    a_unmapped_zero: assert property (s_rd ##0 !(i_io_addr inside {8'h20, 8'h21, 8'ha0,
        8'ha1}) |=> o_io_rdata == 8'h00) else $error("Unmapped read not zero.");
    a_rdata_hold: assert property (!(i_ce && i_io_rd) |=> $stable(o_io_rdata))
        else $error("Read data moved.");
    a_ce_freeze: assert property (!i_ce |=> $stable(o_int) && $stable(o_vector))
        else $error("State moved while frozen.");
    a_masked_rise: assert property ($rose(o_int) |-> $past(mask_ff) != 8'hff
        || $past(mask_ff, 2) != 8'hff) else $error("Interrupt while masked.");
endmodule
bind pic_top pic_top_props u_props (.i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_ce(i_ce),
    .i_io_addr(i_io_addr), .i_io_wdata(i_io_wdata), .i_io_wr(i_io_wr), .i_io_rd(i_io_rd),
    .o_io_rdata(o_io_rdata), .i_int_ack(i_int_ack), .o_int(o_int), .o_vector(o_vector));

// [dv/pic_top_test.sv]
`timescale 1ns/100ps
module pic_top_test;
    reg        clk = 1'b0, rst_n = 1'b0, ce = 1'b1, wr = 1'b0, rd = 1'b0;
    reg  [7:0] req = 8'h00, req2 = 8'h00, adr = 8'h00, wd = 8'h00;
    wire       ack, irq;
    wire [7:0] rdat, vec;
    integer    error_cnt = 0, samples_checked = 0, i;
    // Core clock of 100 ns.
    always #50 clk = ~clk;
    pic_top u_dut (.i_core_clk(clk), .i_resetn(rst_n), .i_ce(ce), .i_request_input_n(req),
        .i_request2_input_n(req2), .i_io_addr(adr), .i_io_wdata(wd), .i_io_wr(wr),
        .i_io_rd(rd), .o_io_rdata(rdat), .i_int_ack(ack), .o_int(irq), .o_vector(vec));
    pic_host u_host (.i_core_clk(clk), .i_int(irq), .o_int_ack(ack));
    task stop_test;
        begin
            $display("errors=%0d checks=%0d", error_cnt, samples_checked);
            if (error_cnt == 0 && samples_checked > 0) $display("*** PASS ***");
            else $display("*** FAIL ***");
            $finish;
        end
    endtask
    task chk(input [7:0] got, input [7:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (got !== exp) begin
                error_cnt = error_cnt + 1;
                $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    // One port access; a read is compared once its data has landed.
    task io(input w, input [7:0] a, input [7:0] d);
        begin
            adr = a;
            wd = d;
            wr = w;
            rd = !w;
            @(negedge clk);
            wr = 1'b0;
            rd = 1'b0;
            @(negedge clk);
            if (!w) chk(rdat, d);
        end
    endtask
    // Raises pins, waits for the interrupt line, checks the vector and the
    // dropped line, then spaces requests. The line is watched rather than the
    // host's acknowledge, which moves on the very edge at which this task looks.
    task serve(input [7:0] p, input [7:0] p2, input [7:0] v);
        begin
            req = p;
            req2 = p2;
            for (i = 0; i < 30 && irq !== 1'b1; i = i + 1) @(negedge clk);
            if (i == 30) error_cnt = error_cnt + 1;
            if (i == 30) stop_test;
            @(negedge clk);
            chk(vec, v);
            chk(irq, 8'h00);
            req = 8'h00;
            req2 = 8'h00;
            repeat (10) @(negedge clk);
        end
    endtask
    // Main sequence.
    initial begin
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        ce = 1'b0;
        repeat (2) @(negedge clk);
        ce = 1'b1;
        io(0, 8'h21, 8'hff);
        io(0, 8'h55, 8'h00);
        io(1, 8'h21, 8'ha5);
        io(0, 8'h21, 8'ha5);
        io(1, 8'h21, 8'h00);
        io(1, 8'ha1, 8'h00);
        io(0, 8'ha1, 8'h00);
        serve(8'h12, 8'h00, 8'h09);
        repeat (12) @(negedge clk);
        chk(irq, 8'h00);
        serve(8'h01, 8'h00, 8'h08);
        io(0, 8'h20, 8'h03);
        io(1, 8'h20, 8'h20);
        io(1, 8'h20, 8'h20);
        serve(8'h00, 8'h00, 8'h0c);
        io(1, 8'h20, 8'h20);
        serve(8'h00, 8'h08, 8'h73);
        io(0, 8'ha0, 8'h08);
        io(0, 8'h20, 8'h04);
        io(1, 8'ha0, 8'h20);
        io(1, 8'h20, 8'h20);
        io(1, 8'h21, 8'hff);
        req = 8'h20;
        repeat (12) @(negedge clk);
        chk(irq, 8'h00);
        stop_test;
    end
endmodule
